// ---- rtl/bss_consts.svh ----
// constants for the backup shutdown/restart sequencer: offsets, fields, resets, timing
// assumes a 50 MHz clock and a 1 ms time-base tick
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
// timing
`define BSS_CLK_NS 20
`define BSS_TICK_NS 1000000
`define BSS_TICK_CYC (`BSS_TICK_NS / `BSS_CLK_NS)
`define BSS_TICK_MS 1
`define BSS_BLINK_HALF_MS 500
`define BSS_BLINK_TICKS (`BSS_BLINK_HALF_MS / `BSS_TICK_MS)
// charge thresholds in percent (20 and 100)
`define BSS_SOC_LOW_PCT 7'h14
`define BSS_SOC_FULL_PCT 7'h64
// register byte offsets
`define BSS_OFF_CTRL 6'h00
`define BSS_OFF_MAXBKP 6'h04
`define BSS_OFF_SDDLY 6'h08
`define BSS_OFF_SDWIN 6'h0c
`define BSS_OFF_MINOFF 6'h10
`define BSS_OFF_DETT 6'h14
`define BSS_OFF_IOFF 6'h18
`define BSS_OFF_CAP 6'h1c
`define BSS_OFF_STATUS 6'h20
`define BSS_OFF_SOC 6'h24
`define BSS_OFF_RES 6'h28
`define BSS_OFF_ISTAT 6'h2c
`define BSS_OFF_IMASK 6'h30
`define BSS_OFF_RIPER 6'h34
// control fields
`define BSS_CTRL_RESTART_EN 0
`define BSS_CTRL_RES_EN 1
// reset values (times in ms ticks)
`define BSS_RST_CTRL 32'h0000_0003
`define BSS_RST_MAXBKP 32'h0036_ee80
`define BSS_RST_SDDLY 32'h0000_ea60
`define BSS_RST_SDWIN 32'h0001_d4c0
`define BSS_RST_MINOFF 32'h0000_2710
`define BSS_RST_DETT 32'h0000_1388
`define BSS_RST_IOFF 32'h0000_0064
`define BSS_RST_CAP 32'h0000_1000
`define BSS_RST_RIPER 32'h0036_ee80
// timer slots
`define BSS_TMR_MAXB 0
`define BSS_TMR_SDD 1
`define BSS_TMR_SDW 2
`define BSS_TMR_MINOFF 3
`define BSS_TMR_HOSTOFF 4
`define BSS_TMR_RIPER 5
`define BSS_NTMR 6
`define BSS_NEV 7
`endif

// ---- rtl/bss_pkg.sv ----
// types for the backup shutdown/restart sequencer
// assumes bss_consts.svh for numeric constants
package bss_pkg;
  typedef logic [31:0] bss_word_t;
  typedef enum logic [2:0] {
    st_normal = 3'b000,
    st_backup = 3'b001,
    st_shutdown = 3'b010,
    st_off = 3'b011,
    st_return_wait = 3'b100,
    st_restart = 3'b101
  } bss_state_e;
endpackage

// ---- rtl/bss_qual_timer.sv ----
// qualified tick counter: counts ticks while run holds, clears the moment it drops
// assumes tick is a one-cycle pulse from the common time base
module bss_qual_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // time base and qualifier
  input wire logic tick,
  input wire logic run,
  input wire logic [31:0] limit,
  // result
  output logic done
);
  import bss_pkg::*;
  bss_word_t cnt_reg;
  bss_word_t cnt_next;
  logic at_limit;
  assign at_limit = (cnt_reg >= limit);
  // saturate at the limit so a long-held qualifier never wraps
  assign cnt_next = !run ? 32'h0000_0000 :
                    (tick && !at_limit) ? cnt_reg + 32'h0000_0001 : cnt_reg;
  assign done = run && at_limit;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  property p_qt_restart;
    @(posedge clk) disable iff (!nrst)
      !run |=> cnt_reg == 32'h0000_0000 && done == (run && limit == 32'h0000_0000);
  endproperty
  a_qt_restart: assert property (p_qt_restart) else $error("timer not cleared");
  property p_qt_count;
    @(posedge clk) disable iff (!nrst)
      run && tick && !at_limit ##1 run |-> cnt_reg == $past(cnt_reg) + 32'h0000_0001;
  endproperty
  a_qt_count: assert property (p_qt_count) else $error("timer missed a tick");
endmodule

// ---- rtl/bss_tick_div.sv ----
// time base: 1 ms tick and a half-second blink enable, both one-cycle pulses
// assumes the single system clock
`include "bss_consts.svh"
module bss_tick_div #(
  parameter int unsigned TICK_CYC = `BSS_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // enables
  output logic tick,
  output logic blink_en
);
  import bss_pkg::*;
  bss_word_t div_reg;
  bss_word_t blk_reg;
  logic div_wrap;
  logic blk_wrap;
  assign div_wrap = (div_reg == 32'(TICK_CYC - 1));
  assign blk_wrap = (blk_reg == 32'(`BSS_BLINK_TICKS - 1));
  assign tick = div_wrap;
  assign blink_en = div_wrap && blk_wrap;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 32'h0000_0000;
      blk_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_wrap ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      if (div_wrap) begin
        blk_reg <= blk_wrap ? 32'h0000_0000 : blk_reg + 32'h0000_0001;
      end
    end
  end
endmodule

// ---- rtl/bss_top.sv ----
// backup shutdown/restart sequencer: power path, host shutdown, restart, health checks
// assumes synchronous sense inputs, an Avalon-MM master, and external relay drivers
`include "bss_consts.svh"

// Summary of operation
// - with input power missing the battery feeds the output and its voltage is watched.
// - a programmable maximum backup time ends battery supply when it runs out.
// - in backup with charge under 20% the ready relay toggles at 1 Hz.
// - remaining charge is reported as a percentage from the charge accumulator.
// - a settable shutdown delay is timed from the start of backup.
// - host shutdown fires on delay expiry or low battery, whichever is first.
// - after shutdown starts the output goes off once the shutdown window elapses.
// - on input return the output stays off for the minimum off time.
// - the host is off once output current stays under threshold for the detect time.
// - host off triggers an output off-on cycle using the minimum off time.
// - restart with input present is done by the host-off relay in series with the output.
// - battery over-temperature disconnects the battery.
// - battery internal resistance is measured periodically and reported.
// - an alternating source current is injected; voltage is taken at sense or terminals.
// - the host restart event is pulsed as the host relay opens for the restart.
module bss_top #(
  parameter int unsigned TICK_CYC = `BSS_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // supply and battery sensing
  input wire logic input_present,
  input wire logic batt_deep_low,
  input wire logic batt_over_temp,
  input wire logic sense_connected,
  input wire logic [15:0] out_current,
  input wire logic [15:0] charge_level,
  input wire logic [11:0] vs_sense,
  input wire logic [11:0] vs_terminal,
  // power path and relays
  output logic batt_to_output,
  output logic batt_disconnect,
  output logic output_on,
  output logic host_relay,
  output logic ready_relay,
  // host events
  output logic host_shutdown_event,
  output logic host_restart_event,
  // resistance measurement
  output logic constant_current_source,
  output logic src_drive,
  output logic vsense_at_remote,
  // interrupt
  output logic irq
);
  import bss_pkg::*;

  // ==========================================================
  // time base and timers
  logic tick;
  logic blink_en;
  bss_tick_div #(.TICK_CYC(TICK_CYC)) u_div (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .blink_en(blink_en)
  );

  bss_state_e state_reg;
  bss_state_e state_next;
  bss_word_t ctrl_reg, maxbkp_reg, sddly_reg, sdwin_reg, minoff_reg;
  bss_word_t dett_reg, ioff_reg, cap_reg, riper_reg;
  logic [`BSS_NTMR-1:0] tmr_run;
  logic [`BSS_NTMR-1:0] tmr_done;
  bss_word_t tmr_limit [`BSS_NTMR];
  logic in_bk;
  logic res_busy_reg;
  logic host_low;

  assign in_bk = (state_reg == st_backup) || (state_reg == st_shutdown);
  assign host_low = (out_current < ioff_reg[15:0]);
  assign tmr_run[`BSS_TMR_MAXB] = in_bk;
  assign tmr_run[`BSS_TMR_SDD] = in_bk;
  assign tmr_run[`BSS_TMR_SDW] = (state_reg == st_shutdown);
  assign tmr_run[`BSS_TMR_MINOFF] = ((state_reg == st_return_wait) && input_present)
                                 || (state_reg == st_restart);
  assign tmr_run[`BSS_TMR_HOSTOFF] = (state_reg == st_normal) && host_low
                                  && ctrl_reg[`BSS_CTRL_RESTART_EN];
  assign tmr_run[`BSS_TMR_RIPER] = (state_reg == st_normal) && !res_busy_reg
                                && ctrl_reg[`BSS_CTRL_RES_EN];
  assign tmr_limit[`BSS_TMR_MAXB] = maxbkp_reg;
  assign tmr_limit[`BSS_TMR_SDD] = sddly_reg;
  assign tmr_limit[`BSS_TMR_SDW] = sdwin_reg;
  assign tmr_limit[`BSS_TMR_MINOFF] = minoff_reg;
  assign tmr_limit[`BSS_TMR_HOSTOFF] = dett_reg;
  assign tmr_limit[`BSS_TMR_RIPER] = riper_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `BSS_NTMR; gi++) begin : g_tmr
      bss_qual_timer u_tmr (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .run(tmr_run[gi]),
        .limit(tmr_limit[gi]),
        .done(tmr_done[gi])
      );
    end
  endgenerate

  // ==========================================================
  // charge estimate
  logic [22:0] pct_prod;
  logic [22:0] pct_raw;
  logic [6:0] soc_reg;
  logic soc_low;
  assign pct_prod = {7'h00, charge_level} * 23'h00_0064;
  assign pct_raw = (cap_reg[15:0] == 16'h0000) ? 23'h00_0000 : pct_prod / {7'h00, cap_reg[15:0]};
  assign soc_low = (soc_reg < `BSS_SOC_LOW_PCT);

  // ==========================================================
  // sequencer
  logic sd_trigger;
  logic bk_end;
  assign sd_trigger = tmr_done[`BSS_TMR_SDD] || soc_low;
  // deep discharge, over-temperature and the backup limit all end battery supply
  assign bk_end = batt_deep_low || batt_over_temp || tmr_done[`BSS_TMR_MAXB];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_normal: begin
        if (!input_present) begin
          state_next = st_backup;
        end else if (tmr_done[`BSS_TMR_HOSTOFF]) begin
          state_next = st_restart;
        end
      end
      st_backup: begin
        if (input_present) begin
          state_next = st_normal;
        end else if (bk_end) begin
          state_next = st_off;
        end else if (sd_trigger) begin
          state_next = st_shutdown;
        end
      end
      st_shutdown: begin
        // the host is already going down, so input return does not abort the window
        if (bk_end || tmr_done[`BSS_TMR_SDW]) begin
          state_next = st_off;
        end
      end
      st_off: begin
        if (input_present) begin
          state_next = st_return_wait;
        end
      end
      st_return_wait: begin
        if (!input_present) begin
          state_next = st_off;
        end else if (tmr_done[`BSS_TMR_MINOFF]) begin
          state_next = st_normal;
        end
      end
      st_restart: begin
        if (tmr_done[`BSS_TMR_MINOFF]) begin
          state_next = st_normal;
        end
      end
      default: state_next = st_off;
    endcase
  end

  assign output_on = in_bk || (state_reg == st_normal);
  assign batt_to_output = in_bk && !batt_over_temp;
  assign batt_disconnect = batt_over_temp;
  // relay in series with the output is the only way to break the input path
  assign host_relay = !output_on;

  // ==========================================================
  // resistance measurement
  logic res_step_reg;
  logic [11:0] vhi_reg;
  logic [11:0] res_reg;
  logic [11:0] vs_mux;
  logic res_done;
  assign vs_mux = sense_connected ? vs_sense : vs_terminal;
  assign vsense_at_remote = sense_connected;
  assign constant_current_source = res_busy_reg;
  assign res_done = res_busy_reg && res_step_reg && tick;

  // ==========================================================
  // interrupts and events
  logic [`BSS_NEV-1:0] ev;
  logic [`BSS_NEV-1:0] istat_reg;
  logic [`BSS_NEV-1:0] imask_reg;
  logic ot_d_reg;
  logic soc_d_reg;
  logic blink_reg;
  assign ev[0] = (state_reg == st_normal) && (state_next == st_backup);
  assign ev[1] = (state_reg == st_backup) && (state_next == st_shutdown);
  assign ev[2] = (state_reg != st_off) && (state_next == st_off);
  assign ev[3] = (state_reg == st_normal) && (state_next == st_restart);
  assign ev[4] = batt_over_temp && !ot_d_reg;
  assign ev[5] = res_done;
  assign ev[6] = in_bk && soc_low && !soc_d_reg;
  assign irq = |(istat_reg & imask_reg);

  // ==========================================================
  // avalon slave: one wait state, answer on the second edge
  logic ack_reg;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [`BSS_NEV-1:0] w1c;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_fire = avs_write && ack_reg;
  assign w1c = (wr_fire && avs_address == `BSS_OFF_ISTAT) ? avs_writedata[`BSS_NEV-1:0]
             : {`BSS_NEV{1'b0}};
  assign status_word = {25'h000_0000, res_busy_reg, soc_low, batt_over_temp,
                        input_present, state_reg};
  always_comb begin
    unique case (avs_address)
      `BSS_OFF_CTRL: rd_mux = ctrl_reg;
      `BSS_OFF_MAXBKP: rd_mux = maxbkp_reg;
      `BSS_OFF_SDDLY: rd_mux = sddly_reg;
      `BSS_OFF_SDWIN: rd_mux = sdwin_reg;
      `BSS_OFF_MINOFF: rd_mux = minoff_reg;
      `BSS_OFF_DETT: rd_mux = dett_reg;
      `BSS_OFF_IOFF: rd_mux = ioff_reg;
      `BSS_OFF_CAP: rd_mux = cap_reg;
      `BSS_OFF_STATUS: rd_mux = status_word;
      `BSS_OFF_SOC: rd_mux = {25'h000_0000, soc_reg};
      `BSS_OFF_RES: rd_mux = {20'h0_0000, res_reg};
      `BSS_OFF_ISTAT: rd_mux = {25'h000_0000, istat_reg};
      `BSS_OFF_IMASK: rd_mux = {25'h000_0000, imask_reg};
      `BSS_OFF_RIPER: rd_mux = riper_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      ctrl_reg <= `BSS_RST_CTRL;
      maxbkp_reg <= `BSS_RST_MAXBKP;
      sddly_reg <= `BSS_RST_SDDLY;
      sdwin_reg <= `BSS_RST_SDWIN;
      minoff_reg <= `BSS_RST_MINOFF;
      dett_reg <= `BSS_RST_DETT;
      ioff_reg <= `BSS_RST_IOFF;
      cap_reg <= `BSS_RST_CAP;
      riper_reg <= `BSS_RST_RIPER;
      imask_reg <= {`BSS_NEV{1'b0}};
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg) begin
        avs_readdata <= rd_mux;
      end
      if (wr_fire) begin
        unique case (avs_address)
          `BSS_OFF_CTRL: ctrl_reg <= avs_writedata;
          `BSS_OFF_MAXBKP: maxbkp_reg <= avs_writedata;
          `BSS_OFF_SDDLY: sddly_reg <= avs_writedata;
          `BSS_OFF_SDWIN: sdwin_reg <= avs_writedata;
          `BSS_OFF_MINOFF: minoff_reg <= avs_writedata;
          `BSS_OFF_DETT: dett_reg <= avs_writedata;
          `BSS_OFF_IOFF: ioff_reg <= avs_writedata;
          `BSS_OFF_CAP: cap_reg <= avs_writedata;
          `BSS_OFF_IMASK: imask_reg <= avs_writedata[`BSS_NEV-1:0];
          `BSS_OFF_RIPER: riper_reg <= avs_writedata;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // state, outputs and measurement registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= st_normal;
      soc_reg <= 7'h00;
      istat_reg <= {`BSS_NEV{1'b0}};
      ot_d_reg <= 1'b0;
      soc_d_reg <= 1'b0;
      blink_reg <= 1'b1;
      ready_relay <= 1'b0;
      host_shutdown_event <= 1'b0;
      host_restart_event <= 1'b0;
      res_busy_reg <= 1'b0;
      res_step_reg <= 1'b0;
      src_drive <= 1'b0;
      vhi_reg <= 12'h000;
      res_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      soc_reg <= (pct_raw > 23'h00_0064) ? `BSS_SOC_FULL_PCT : pct_raw[6:0];
      istat_reg <= (istat_reg & ~w1c) | ev; // set beats clear
      ot_d_reg <= batt_over_temp;
      soc_d_reg <= in_bk && soc_low;
      if (in_bk && soc_low) begin
        blink_reg <= blink_en ? !blink_reg : blink_reg;
      end else begin
        blink_reg <= 1'b1;
      end
      ready_relay <= output_on && blink_reg;
      host_shutdown_event <= ev[1];
      host_restart_event <= ev[3];
      if (!res_busy_reg) begin
        if (tmr_done[`BSS_TMR_RIPER]) begin
          res_busy_reg <= 1'b1;
          res_step_reg <= 1'b0;
          src_drive <= 1'b1;
        end
      end else if (tick) begin
        res_step_reg <= 1'b1;
        src_drive <= 1'b0;
        if (!res_step_reg) begin
          vhi_reg <= vs_mux;
        end else begin
          res_busy_reg <= 1'b0;
          res_reg <= (vhi_reg > vs_mux) ? vhi_reg - vs_mux : vs_mux - vhi_reg;
        end
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_enter_backup;
    state_reg == st_normal && !input_present |=> state_reg == st_backup && batt_to_output
      || batt_over_temp;
  endproperty
  a_enter_backup: assert property (p_enter_backup) else $error("backup not entered");
  property p_max_backup;
    in_bk && tmr_done[`BSS_TMR_MAXB] && (state_reg == st_shutdown || !input_present)
      |=> state_reg == st_off && !output_on;
  endproperty
  a_max_backup: assert property (p_max_backup) else $error("backup limit ignored");
  property p_blink;
    in_bk && soc_low && blink_en ##1 in_bk && soc_low |=> ready_relay != $past(ready_relay);
  endproperty
  a_blink: assert property (p_blink) else $error("ready relay not toggling");
  property p_soc_range;
    soc_reg <= `BSS_SOC_FULL_PCT;
  endproperty
  a_soc_range: assert property (p_soc_range) else $error("charge above full");
  property p_shutdown_event;
    state_reg == st_backup ##1 state_reg == st_shutdown |-> host_shutdown_event;
  endproperty
  a_shutdown_event: assert property (p_shutdown_event) else $error("no shutdown event");
  property p_window;
    state_reg == st_shutdown && tmr_done[`BSS_TMR_SDW] |=> !output_on ##1 !output_on;
  endproperty
  a_window: assert property (p_window) else $error("output kept after window");
  property p_min_off;
    state_reg == st_return_wait && !tmr_done[`BSS_TMR_MINOFF] |=> !output_on;
  endproperty
  a_min_off: assert property (p_min_off) else $error("output on too early");
  property p_host_off;
    $rose(state_reg == st_restart) |-> $past(tmr_done[`BSS_TMR_HOSTOFF]) && $past(host_low);
  endproperty
  a_host_off: assert property (p_host_off) else $error("restart without host off");
  property p_restart_relay;
    state_reg == st_restart |-> host_relay && !output_on && !batt_to_output;
  endproperty
  a_restart_relay: assert property (p_restart_relay) else $error("relay not open");
  property p_over_temp;
    batt_over_temp |-> batt_disconnect && !batt_to_output;
  endproperty
  a_over_temp: assert property (p_over_temp) else $error("battery kept hot");
  property p_res_src;
    $rose(res_busy_reg) |-> src_drive && constant_current_source;
  endproperty
  a_res_src: assert property (p_res_src) else $error("source not driven");
  c_backup_shutdown: cover property (state_reg == st_shutdown ##1 state_reg == st_off);
  c_restart: cover property (state_reg == st_restart ##1 state_reg == st_normal);
  c_res: cover property (res_done);
endmodule

// ---- sim/backup_shutdown_restart_sequencer_test.sv ----
// self-checking bench for the backup shutdown/restart sequencer
// assumes bss_host_model as the load and a 4-clock time-base tick
`include "bss_consts.svh"
module backup_shutdown_restart_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 4;
  localparam int SDD = 6;
  localparam int SDW = 8;
  localparam int MOF = 5;
  localparam int DET = 4;
  logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic avs_waitrequest, batt_to_output, batt_disconnect, output_on, host_relay;
  logic ready_relay, host_shutdown_event, host_restart_event, constant_current_source;
  logic src_drive, vsense_at_remote, irq, crash = 1'b0;
  logic input_present = 1'b1, batt_deep_low = 1'b0, batt_over_temp = 1'b0;
  logic sense_connected = 1'b1;
  logic [15:0] charge_level = 16'hffff, out_current;
  logic [11:0] vs_sense, vs_terminal;
  int n_fail = 0, samples_checked = 0, n, m, n_sd = 0, seed = 32'h1417;
  // sense sees the larger swing: cable drop adds only at the terminals
  assign vs_sense = src_drive ? 12'h380 : 12'h200;
  assign vs_terminal = src_drive ? 12'h2c0 : 12'h200;
  always #10 clk = ~clk;
  always @(posedge clk) n_sd <= n_sd + host_shutdown_event;
  bss_top #(.TICK_CYC(TC)) uut (.*);
  bss_host_model host (.*);
  // ========
  // checking and bus helpers
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
    int k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50) n_fail++;
  endtask
  function automatic logic sig(int s);
    return s == 0 ? host_shutdown_event : s == 1 ? output_on : s == 2 ? host_restart_event
      : s == 3 ? ready_relay : constant_current_source;
  endfunction
  // t ticks expected; t of 0 only bounds the wait
  task automatic wait_for(int s, logic v, int t, string nm);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(s) !== v && n < 20000);
    check(nm, n >= (t > 0 ? (t - 1) * TC : 0) && n <= (t > 0 ? t * TC + 6 : 19999), 1'b1);
  endtask
  function automatic logic [31:0] soc_exp(logic [15:0] c);
    logic [31:0] p;
    p = {16'h0000, c} * 32'h0000_0064 / 32'h0000_1000;
    return p > 32'h0000_0064 ? 32'h0000_0064 : p;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `BSS_OFF_CTRL, 32'h0);
    check("ctrl_reset", q, `BSS_RST_CTRL);
    bus(1'b1, `BSS_OFF_STATUS, 32'h0000_00ff);
    bus(1'b0, `BSS_OFF_STATUS, 32'h0);
    check("status", q[3:0], 4'h8);
    bus(1'b0, 6'h3c, 32'h0);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      charge_level <= i == 0 ? 16'h0333 : (i == 1 ? 16'hffff : 16'($random(seed)));
      bus(1'b0, `BSS_OFF_SOC, 32'h0);
      check("soc", q, soc_exp(charge_level));
    end
    charge_level <= 16'hffff;
    bus(1'b1, `BSS_OFF_SDDLY, SDD);
    bus(1'b1, `BSS_OFF_SDWIN, SDW);
    bus(1'b1, `BSS_OFF_MINOFF, MOF);
    bus(1'b1, `BSS_OFF_DETT, DET);
    input_present <= 1'b0;
    wait_for(0, 1'b1, SDD, "shutdown_delay");
    check("battery_feed", batt_to_output, 1'b1);
    // input back mid-shutdown must not stop the window
    input_present <= 1'b1;
    wait_for(1, 1'b0, SDW, "shutdown_window");
    wait_for(1, 1'b1, MOF, "min_off_time");
    check("shutdown_count", n_sd, 1);
    bus(1'b0, `BSS_OFF_ISTAT, 32'h0);
    check("istat", q, 32'h0000_0007);
    check("irq_masked", irq, 1'b0);
    bus(1'b1, `BSS_OFF_IMASK, 32'h0000_0001);
    @(negedge clk);
    check("irq_set", irq, 1'b1);
    bus(1'b1, `BSS_OFF_ISTAT, 32'h0000_0001);
    @(negedge clk);
    check("irq_clear", irq, 1'b0);
    crash <= 1'b1;
    wait_for(2, 1'b1, DET, "host_off_detect");
    crash <= 1'b0;
    check("restart_relay", {host_relay, output_on}, 2'b10);
    wait_for(1, 1'b1, MOF, "restart_off_time");
    batt_over_temp <= 1'b1;
    @(negedge clk);
    check("disconnect", batt_disconnect, 1'b1);
    bus(1'b0, `BSS_OFF_ISTAT, 32'h0);
    check("over_temp_event", q[4], 1'b1);
    batt_over_temp <= 1'b0;
    bus(1'b1, `BSS_OFF_SDDLY, 32'h0000_03e8);
    for (int k = 0; k < 2; k++) begin
      m = n_sd;
      bus(1'b1, `BSS_OFF_MAXBKP, k ? 32'h0000_0003 : 32'h0000_03e8);
      batt_deep_low <= (k == 0);
      input_present <= 1'b0;
      wait_for(1, 1'b0, k ? 3 : 1, "early_off");
      check("no_shutdown", n_sd, m);
      batt_deep_low <= 1'b0;
      input_present <= 1'b1;
      wait_for(1, 1'b1, MOF, "return_off_time");
    end
    bus(1'b1, `BSS_OFF_MAXBKP, 32'h0000_ffff);
    bus(1'b1, `BSS_OFF_SDWIN, 32'h0000_04b0);
    charge_level <= 16'h0100;
    input_present <= 1'b0;
    wait_for(0, 1'b1, 1, "low_alarm");
    bus(1'b0, `BSS_OFF_SOC, 32'h0);
    check("backup_soc", q, 32'h0000_0006);
    @(ready_relay);
    wait_for(3, !ready_relay, 500, "blink_half");
    charge_level <= 16'hffff;
    input_present <= 1'b1;
    wait_for(1, 1'b0, 0, "window_end");
    wait_for(1, 1'b1, MOF, "final_return");
    bus(1'b1, `BSS_OFF_RIPER, 32'h0000_0003);
    wait_for(4, 1'b1, 0, "source_on");
    check("drive_phase", src_drive, 1'b1);
    for (int s = 1; s >= 0; s--) begin
      sense_connected <= s[0];
      // two passes so no sample straddles the sense change
      repeat (2) begin
        bus(1'b1, `BSS_OFF_ISTAT, 32'h0000_007f);
        do bus(1'b0, `BSS_OFF_ISTAT, 32'h0); while (q[5] !== 1'b1);
      end
      bus(1'b0, `BSS_OFF_RES, 32'h0);
      check("resistance", q, s ? 32'h0000_0180 : 32'h0000_00c0);
      check("remote_sense", vsense_at_remote, s[0]);
    end
    // a second reset in mid-run must restore the settings
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `BSS_OFF_SDDLY, 32'h0);
    check("sddly_reset", q, `BSS_RST_SDDLY);
    end_of_test();
  end
endmodule

// ---- sim/bss_host_model.sv ----
// host computer model fed from the backed-up output
// assumes the sequencer's output_on, host_relay and shutdown event
module bss_host_model #(
  parameter int SHUT_CYC = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // power and commands
  input wire logic output_on,
  input wire logic host_relay,
  input wire logic host_shutdown_event,
  input wire logic crash,
  // load current
  output logic [15:0] out_current
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run_reg, pwr_reg;
  int sd_cnt;
  // the series relay cuts the feed even with input present
  wire logic pwr = output_on & !host_relay;
  // ========
  // boot on power-up, halt well inside the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_reg <= 1'b1;
      pwr_reg <= 1'b1;
      sd_cnt <= 0;
    end else begin
      pwr_reg <= pwr;
      sd_cnt <= host_shutdown_event ? SHUT_CYC : (sd_cnt > 0 ? sd_cnt - 1 : 0);
      if (!pwr || crash || sd_cnt == 1)
        run_reg <= 1'b0;
      else if (!pwr_reg)
        run_reg <= 1'b1;
    end
  end
  // an unpowered or halted host draws nothing
  assign out_current = (pwr && run_reg) ? 16'h0400 : 16'h0000;
endmodule
